/* design/gep_pkg.sv */
// Constants, limits and encodings shared by the genset protection block
package gep_pkg;

   // ********************************************************
   // Time base
   // ********************************************************
   // System clock rate and the one-second protection tick
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned TICK_TIME_S = 1;
   localparam int unsigned TICK_CYCLES = TICK_TIME_S * CLK_HZ;
   localparam int unsigned TICK_CNT_W = 28;

   // ********************************************************
   // Widths
   // ********************************************************
   localparam int unsigned CUR_W = 16;
   localparam int unsigned KW_W = 18;
   localparam int unsigned LIM_W = 16;
   localparam int unsigned PCT_W = 7;
   localparam int unsigned SUM_W = 18;
   localparam int unsigned PROD_W = 26;

   // ********************************************************
   // Factory values and fixed counts
   // ********************************************************
   localparam logic [6:0] RP_FAIL_DEF = 7'h05;
   localparam logic [6:0] OL_FAIL_DEF = 7'h03;
   localparam logic [6:0] OC_MULT_DEF = 7'h10;
   localparam logic [15:0] MAINS_WAIT_DEF = 16'h001E;
   localparam logic [2:0] TOPO_DEF = 3'h5;
   // Overcurrent accumulator level that declares the fault
   localparam logic [15:0] OC_TRIP_LEVEL = 16'h0100;
   // Percent scale of the unbalance comparison
   localparam logic [6:0] PCT_SCALE = 7'h64;
   localparam logic [5:0] SEC_PER_MIN = 6'h3C;
   // Gap counters saturate here; reset value lets the first add pass
   localparam logic [7:0] ADD_GAP_MAX = 8'hFF;
   localparam logic [12:0] SUB_GAP_MAX = 13'h1FFF;

   // ********************************************************
   // Encodings
   // ********************************************************
   typedef enum logic [1:0] {
      GEP_UNB_NONE = 2'h0,
      GEP_UNB_SHUTDOWN = 2'h1,
      GEP_UNB_LOADDUMP = 2'h2,
      GEP_UNB_WARN = 2'h3
   } gep_unb_act_e;

   typedef enum logic [1:0] {
      GEP_OC_SHUTDOWN = 2'h0,
      GEP_OC_LOADDUMP = 2'h1
   } gep_oc_act_e;

   typedef enum logic [1:0] {
      GEP_VSEL_PRI = 2'h0,
      GEP_VSEL_SEC = 2'h1,
      GEP_VSEL_TER = 2'h2
   } gep_vsel_e;

   typedef enum logic [2:0] {
      GEP_TOPO_2P_L12 = 3'h0,
      GEP_TOPO_2P_L13 = 3'h1,
      GEP_TOPO_3P3W = 3'h2,
      GEP_TOPO_2CT_L12 = 3'h3,
      GEP_TOPO_2CT_L13 = 3'h4,
      GEP_TOPO_STAR = 3'h5,
      GEP_TOPO_DELTA = 3'h6,
      GEP_TOPO_1P = 3'h7
   } gep_topo_e;

endpackage

/* design/gep_persist.sv */
// Persistence timer: qualifies a condition over one-second ticks
`timescale 1ns/10ps
`default_nettype none

module gep_persist
   import gep_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic cond,
   input wire logic tick,
   input wire logic [6:0] step,
   input wire logic [15:0] limit,
   output logic expired
);

   logic [15:0] cnt;
   logic [16:0] sum;

   // Wide sum so the saturation test cannot wrap
   assign sum = {1'b0, cnt} + {10'h000, step};

   // Count while the condition holds, restart from zero when it drops
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 16'h0000;
      end else if (!cond) begin
         cnt <= 16'h0000;
      end else if (tick && cnt < limit) begin
         cnt <= sum[16] ? 16'hFFFF : sum[15:0];
      end
   end

   // A zero limit expires as soon as the condition is seen
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         expired <= 1'b0;
      end else begin
         expired <= cond && (cnt >= limit);
      end
   end

endmodule

`default_nettype wire

/* design/gep_protect.sv */
// Genset electrical protection, load shedding and topology decode
`timescale 1ns/10ps
`default_nettype none

module gep_protect
   import gep_pkg::*;
#(
   parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [15:0] cur_l1,
   input wire logic [15:0] cur_l2,
   input wire logic [15:0] cur_l3,
   input wire logic signed [17:0] gen_kw,
   input wire logic load_fed,
   input wire logic mains_ok,
   input wire logic [6:0] unb_limit,
   input wire logic [1:0] unb_action,
   input wire logic [15:0] rp_warn_limit,
   input wire logic [15:0] rp_ld_limit,
   input wire logic [6:0] rp_fail_time,
   input wire logic [15:0] oc_limit1,
   input wire logic [15:0] oc_limit2,
   input wire logic [15:0] oc_limit3,
   input wire logic [1:0] volt_sel,
   input wire logic [1:0] oc_action,
   input wire logic [6:0] oc_mult,
   input wire logic [15:0] ol_limit,
   input wire logic [6:0] ol_fail_time,
   input wire logic [15:0] shed_low,
   input wire logic [15:0] shed_high,
   input wire logic [7:0] add_delay,
   input wire logic [6:0] sub_add_delay,
   input wire logic [15:0] mains_wait,
   input wire logic [2:0] mains_topo,
   input wire logic [2:0] gen_topo,
   input wire logic add_req,
   input wire logic sub_req,
   output logic unb_warn,
   output logic unb_loaddump,
   output logic unb_shutdown,
   output logic rp_warn,
   output logic rp_loaddump,
   output logic oc_shutdown,
   output logic oc_loaddump,
   output logic ol_loaddump,
   output logic engine_stop,
   output logic shed_relay,
   output logic load_add_pulse,
   output logic load_sub_pulse,
   output logic gen_release,
   output logic [2:0] mains_vmask,
   output logic [2:0] mains_imask,
   output logic mains_delta,
   output logic [2:0] gen_vmask,
   output logic [2:0] gen_imask,
   output logic gen_delta
);

   // ********************************************************
   // Topology decode
   // ********************************************************
   // Returns {voltage phase mask, current transformer mask}
   function automatic logic [5:0] topo_masks(input logic [2:0] code);
      logic [5:0] m;
      m = 6'h3F;
      case (gep_topo_e'(code))
         GEP_TOPO_2P_L12: m = 6'h1B;
         GEP_TOPO_2P_L13: m = 6'h2D;
         GEP_TOPO_3P3W: m = 6'h3F;
         GEP_TOPO_2CT_L12: m = 6'h3B;
         GEP_TOPO_2CT_L13: m = 6'h3D;
         GEP_TOPO_STAR: m = 6'h3F;
         GEP_TOPO_DELTA: m = 6'h3F;
         GEP_TOPO_1P: m = 6'h09;
         default: m = 6'h3F;
      endcase
      return m;
   endfunction

   logic [5:0] next_mains_masks;
   logic [5:0] next_gen_masks;
   assign next_mains_masks = topo_masks(mains_topo);
   assign next_gen_masks = topo_masks(gen_topo);

   // Registered so the masks are clean data outputs
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mains_vmask <= 3'h7;
         mains_imask <= 3'h7;
         mains_delta <= 1'b0;
         gen_vmask <= 3'h7;
         gen_imask <= 3'h7;
         gen_delta <= 1'b0;
      end else begin
         mains_vmask <= next_mains_masks[5:3];
         mains_imask <= next_mains_masks[2:0];
         mains_delta <= (mains_topo == GEP_TOPO_DELTA);
         gen_vmask <= next_gen_masks[5:3];
         gen_imask <= next_gen_masks[2:0];
         gen_delta <= (gen_topo == GEP_TOPO_DELTA);
      end
   end

   // ********************************************************
   // One-second tick
   // ********************************************************
   logic [TICK_CNT_W-1:0] tick_cnt;
   logic tick;
   assign tick = (tick_cnt == TICK_CNT_W'(TICK_CYCLES_P - 1));
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tick_cnt <= '0;
      end else if (tick) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + TICK_CNT_W'(1);
      end
   end

   // ********************************************************
   // Phase current checks
   // ********************************************************
   logic [15:0] cur [3];
   logic [2:0] use_ph;
   logic [1:0] n_used;
   logic [SUM_W-1:0] cur_sum;
   logic [PROD_W-1:0] unb_rhs;
   logic [15:0] oc_lim;
   logic [2:0] oc_hit;
   logic [2:0] unb_hit;
   assign cur[0] = cur_l1;
   assign cur[1] = cur_l2;
   assign cur[2] = cur_l3;
   // absent phases do not take part in any check
   assign use_ph = next_gen_masks[2:0];
   assign n_used = 2'({1'b0, use_ph[0]} + {1'b0, use_ph[1]} + {1'b0, use_ph[2]});
   assign cur_sum = (use_ph[0] ? SUM_W'(cur[0]) : '0)
      + (use_ph[1] ? SUM_W'(cur[1]) : '0)
      + (use_ph[2] ? SUM_W'(cur[2]) : '0);
   assign unb_rhs = PROD_W'(unb_limit) * PROD_W'(cur_sum);
   // limit follows the selected voltage set
   always_comb begin
      case (gep_vsel_e'(volt_sel))
         GEP_VSEL_SEC: oc_lim = oc_limit2;
         GEP_VSEL_TER: oc_lim = oc_limit3;
         default: oc_lim = oc_limit1;
      endcase
   end

   // Division is avoided: 100*|n*I - sum| > limit*sum is the same test
   for (genvar k = 0; k < 3; k++) begin : g_phase
      logic [SUM_W-1:0] scaled;
      logic [SUM_W-1:0] dev;
      assign scaled = SUM_W'(cur[k]) * SUM_W'(n_used);
      assign dev = (scaled >= cur_sum) ? scaled - cur_sum : cur_sum - scaled;
      assign unb_hit[k] = use_ph[k] && (PROD_W'(dev) * PROD_W'(PCT_SCALE) > unb_rhs);
      assign oc_hit[k] = use_ph[k] && (cur[k] > oc_lim);
   end

   // ********************************************************
   // Current unbalance
   // ********************************************************
   logic unb_fault;
   assign unb_fault = (unb_limit != 7'h00) && (cur_sum != '0) && (|unb_hit);
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         unb_warn <= 1'b0;
         unb_loaddump <= 1'b0;
         unb_shutdown <= 1'b0;
      end else begin
         unb_shutdown <= unb_fault && (unb_action == GEP_UNB_SHUTDOWN);
         unb_loaddump <= unb_fault && (unb_action == GEP_UNB_LOADDUMP);
         unb_warn <= unb_fault && (unb_action == GEP_UNB_WARN);
      end
   end

   // ********************************************************
   // Reverse power
   // ********************************************************
   logic rp_neg;
   logic [17:0] rp_mag;
   logic rp_warn_cond;
   logic rp_ld_cond;
   assign rp_neg = gen_kw[17];
   assign rp_mag = 18'(-gen_kw);
   // zero warning limit turns off the whole supervision
   assign rp_warn_cond = (rp_warn_limit != 16'h0000) && rp_neg && (rp_mag > 18'(rp_warn_limit));
   assign rp_ld_cond = (rp_warn_limit != 16'h0000) && (rp_ld_limit != 16'h0000)
      && rp_neg && (rp_mag > 18'(rp_ld_limit));

   gep_persist u_rp_warn (
      .mclk(mclk), .arst_n(arst_n), .cond(rp_warn_cond), .tick(tick),
      .step(7'h01), .limit({9'h000, rp_fail_time}), .expired(rp_warn)
   );
   gep_persist u_rp_ld (
      .mclk(mclk), .arst_n(arst_n), .cond(rp_ld_cond), .tick(tick),
      .step(7'h01), .limit({9'h000, rp_fail_time}), .expired(rp_loaddump)
   );

   // ********************************************************
   // Overcurrent
   // ********************************************************
   logic oc_cond;
   logic oc_trip;
   // only while the contactor is closed
   assign oc_cond = load_fed && (oc_lim != 16'h0000) && (|oc_hit);
   // multiplier is the step per second toward a fixed level
   gep_persist u_oc (
      .mclk(mclk), .arst_n(arst_n), .cond(oc_cond), .tick(tick),
      .step(oc_mult), .limit(OC_TRIP_LEVEL), .expired(oc_trip)
   );

   // codes 2 and 3 fall back to the safer shutdown
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         oc_shutdown <= 1'b0;
         oc_loaddump <= 1'b0;
      end else begin
         oc_shutdown <= oc_trip && (oc_action != GEP_OC_LOADDUMP);
         oc_loaddump <= oc_trip && (oc_action == GEP_OC_LOADDUMP);
      end
   end

   // ********************************************************
   // Overload
   // ********************************************************
   logic ol_cond;
   // total power over limit while feeding
   assign ol_cond = load_fed && (ol_limit != 16'h0000) && !gen_kw[17]
      && (gen_kw > $signed({2'b00, ol_limit}));

   gep_persist u_ol (
      .mclk(mclk), .arst_n(arst_n), .cond(ol_cond), .tick(tick),
      .step(7'h01), .limit({9'h000, ol_fail_time}), .expired(ol_loaddump)
   );

   // ********************************************************
   // Engine stop
   // ********************************************************
   // any shutdown class alarm stops the engine
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         engine_stop <= 1'b0;
      end else begin
         engine_stop <= unb_shutdown || oc_shutdown;
      end
   end

   // ********************************************************
   // Load shedding relay
   // ********************************************************
   // Low limit wins if the two limits overlap, so the relay never chatters
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         shed_relay <= 1'b0;
      end else if (gen_kw < $signed({2'b00, shed_low})) begin
         shed_relay <= 1'b0;
      end else if (gen_kw > $signed({2'b00, shed_high})) begin
         shed_relay <= 1'b1;
      end
   end

   // ********************************************************
   // Load add and subtract pulses
   // ********************************************************
   logic [7:0] add_gap;
   logic [12:0] sub_gap;
   logic [12:0] sub_gap_need;
   logic add_ok;
   assign sub_gap_need = 13'(sub_add_delay) * 13'(SEC_PER_MIN);
   // both spacings must have run out
   assign add_ok = add_req && !sub_req && (add_gap >= add_delay) && (sub_gap >= sub_gap_need);

   // Subtracting is never delayed: shedding load is the safe direction
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         load_sub_pulse <= 1'b0;
         load_add_pulse <= 1'b0;
      end else begin
         load_sub_pulse <= sub_req;
         load_add_pulse <= add_ok;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         add_gap <= ADD_GAP_MAX;
      end else if (add_ok) begin
         add_gap <= 8'h00;
      end else if (tick && add_gap != ADD_GAP_MAX) begin
         add_gap <= add_gap + 8'h01;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sub_gap <= SUB_GAP_MAX;
      end else if (sub_req) begin
         sub_gap <= 13'h0000;
      end else if (tick && sub_gap != SUB_GAP_MAX) begin
         sub_gap <= sub_gap + 13'h0001;
      end
   end

   // ********************************************************
   // Return to mains
   // ********************************************************
   // mains must stay healthy for the waiting time
   gep_persist u_mains (
      .mclk(mclk), .arst_n(arst_n), .cond(mains_ok), .tick(tick),
      .step(7'h01), .limit(mains_wait), .expired(gen_release)
   );

endmodule

`default_nettype wire

/* tb/gep_protect_monitor.sv */
// Port-level checker for the genset protection block
`timescale 1ns/10ps
`default_nettype none
// ********************************************************
// Checker
// ********************************************************
module gep_protect_monitor
   import gep_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic signed [17:0] gen_kw,
   input wire logic load_fed,
   input wire logic [6:0] unb_limit,
   input wire logic [1:0] unb_action,
   input wire logic [15:0] shed_low,
   input wire logic [15:0] shed_high,
   input wire logic [2:0] gen_topo,
   input wire logic add_req,
   input wire logic sub_req,
   input wire logic unb_warn,
   input wire logic unb_loaddump,
   input wire logic unb_shutdown,
   input wire logic oc_shutdown,
   input wire logic oc_loaddump,
   input wire logic ol_loaddump,
   input wire logic engine_stop,
   input wire logic shed_relay,
   input wire logic load_add_pulse,
   input wire logic load_sub_pulse,
   input wire logic gen_delta
);
   // One clock domain, so clock and reset are given once
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // Limits are unsigned kW; widen them so negative power compares low
   // relay off
   property p_shed_off; gen_kw < $signed({2'h0, shed_low}) |=> !shed_relay; endproperty
   a_shed_off: assert property (p_shed_off) else $error("shed relay on below low limit");
   property p_shed_on; !(gen_kw < $signed({2'h0, shed_low})) && gen_kw > $signed({2'h0, shed_high})
      |=> shed_relay; endproperty
   a_shed_on: assert property (p_shed_on) else $error("shed relay off above high limit");
   property p_shed_hold; !(gen_kw < $signed({2'h0, shed_low})) && !(gen_kw > $signed({2'h0, shed_high}))
      |=> shed_relay == $past(shed_relay); endproperty
   a_shed_hold: assert property (p_shed_hold) else $error("shed relay moved inside the band");
   property p_add_src; load_add_pulse |-> $past(add_req) && !$past(sub_req); endproperty
   a_add_src: assert property (p_add_src) else $error("add pulse without a lone add request");
   property p_sub; sub_req |=> load_sub_pulse; endproperty
   a_sub: assert property (p_sub) else $error("subtract request gave no pulse");
   property p_fed_mask; !load_fed [*3] |-> !oc_shutdown && !oc_loaddump && !ol_loaddump; endproperty
   a_fed_mask: assert property (p_fed_mask) else $error("feeding alarm with contactor open");
   property p_unb_off; unb_limit == 7'h00 [*2] |-> !(unb_warn || unb_loaddump || unb_shutdown); endproperty
   a_unb_off: assert property (p_unb_off) else $error("unbalance alarm with zero limit");
   property p_unb_act; unb_warn || unb_loaddump || unb_shutdown
      |-> $past(unb_action) == {unb_warn | unb_loaddump, unb_warn | unb_shutdown}; endproperty
   a_unb_act: assert property (p_unb_act) else $error("unbalance alarm class differs from action");
   property p_stop; unb_shutdown || oc_shutdown |=> engine_stop; endproperty
   a_stop: assert property (p_stop) else $error("shutdown alarm without engine stop");
   property p_delta; gen_topo == 3'h6 |=> gen_delta; endproperty
   a_delta: assert property (p_delta) else $error("delta code not decoded");
endmodule

bind gep_protect gep_protect_monitor u_mon (.mclk, .arst_n, .gen_kw, .load_fed, .unb_limit, .unb_action, .shed_low,
   .shed_high, .gen_topo, .add_req, .sub_req, .unb_warn, .unb_loaddump, .unb_shutdown, .oc_shutdown, .oc_loaddump,
   .ol_loaddump, .engine_stop, .shed_relay, .load_add_pulse, .load_sub_pulse, .gen_delta);
`default_nettype wire

/* tb/gep_genset_model.sv */
// Behavioural generator set: phase currents, power and contactor states
`timescale 1ns/10ps
`default_nettype none
// ********************************************************
// Generator set model
// ********************************************************
module gep_genset_model (
   output logic [15:0] cur_l1,
   output logic [15:0] cur_l2,
   output logic [15:0] cur_l3,
   output logic signed [17:0] gen_kw,
   output logic load_fed,
   output logic mains_ok
);
   // Balanced idle machine, contactor open, mains absent
   initial begin
      cur_l1 = 16'h0064;
      cur_l2 = 16'h0064;
      cur_l3 = 16'h0064;
      gen_kw = 18'sh0;
      load_fed = 1'b0;
      mains_ok = 1'b0;
   end
   // One reading changes all together; L3 alone swings to build unbalance
   task set_meas(input logic [15:0] l3, input logic signed [17:0] kw, input logic fed, input logic ok);
      cur_l3 = l3;
      gen_kw = kw;
      load_fed = fed;
      mains_ok = ok;
   endtask
endmodule
`default_nettype wire

/* tb/tb_genset_electrical_protection.sv */
// Self-checking bench for the genset protection block
`timescale 1ns/10ps
`default_nettype none
// ********************************************************
// Bench
// ********************************************************
module tb_genset_electrical_protection
   import gep_pkg::*;
;
   typedef struct packed {
      logic hi;
      logic [6:0] lim;
      logic [1:0] act;
      logic [2:0] topo;
      logic [2:0] unb;
      logic [2:0] vm;
      logic [2:0] im;
   } gep_row_s;
   logic mclk, arst_n, load_fed, mains_ok, add_req, sub_req;
   logic [15:0] cur_l1, cur_l2, cur_l3, rp_warn_limit, rp_ld_limit, oc_limit1, oc_limit2, oc_limit3;
   logic [15:0] ol_limit, shed_low, shed_high, mains_wait;
   logic signed [17:0] gen_kw;
   logic [6:0] unb_limit, rp_fail_time, oc_mult, ol_fail_time, sub_add_delay;
   logic [1:0] unb_action, volt_sel, oc_action;
   logic [7:0] add_delay;
   logic [2:0] mains_topo, gen_topo, mains_vmask, mains_imask, gen_vmask, gen_imask;
   logic unb_warn, unb_loaddump, unb_shutdown, rp_warn, rp_loaddump, oc_shutdown, oc_loaddump, ol_loaddump;
   logic engine_stop, shed_relay, load_add_pulse, load_sub_pulse, gen_release, mains_delta, gen_delta;
   int fails, num_checks, n;
   // Unbalance class {warn,loaddump,shutdown} and masks per topology; limits 33 and 34 straddle 33.3 percent
   gep_row_s rows [13] = '{'{1'h0,7'h14,2'h1,3'h0,3'h0,3'h3,3'h3}, '{1'h0,7'h14,2'h2,3'h1,3'h0,3'h5,3'h5},
      '{1'h0,7'h14,2'h3,3'h2,3'h0,3'h7,3'h7}, '{1'h0,7'h14,2'h1,3'h3,3'h0,3'h7,3'h3},
      '{1'h0,7'h14,2'h1,3'h4,3'h0,3'h7,3'h5}, '{1'h0,7'h14,2'h1,3'h6,3'h0,3'h7,3'h7},
      '{1'h0,7'h14,2'h1,3'h7,3'h0,3'h1,3'h1}, '{1'h1,7'h14,2'h0,3'h5,3'h0,3'h7,3'h7},
      '{1'h1,7'h14,2'h1,3'h5,3'h1,3'h7,3'h7}, '{1'h1,7'h14,2'h2,3'h5,3'h2,3'h7,3'h7},
      '{1'h1,7'h21,2'h3,3'h5,3'h4,3'h7,3'h7}, '{1'h1,7'h00,2'h3,3'h5,3'h0,3'h7,3'h7},
      '{1'h1,7'h22,2'h3,3'h5,3'h0,3'h7,3'h7}};

   gep_genset_model gs (.cur_l1, .cur_l2, .cur_l3, .gen_kw, .load_fed, .mains_ok);
   // Four-cycle second keeps every timer short
   gep_protect #(.TICK_CYCLES_P(4)) DUT (.mclk, .arst_n, .cur_l1, .cur_l2, .cur_l3, .gen_kw, .load_fed, .mains_ok,
      .unb_limit, .unb_action, .rp_warn_limit, .rp_ld_limit, .rp_fail_time, .oc_limit1, .oc_limit2, .oc_limit3,
      .volt_sel, .oc_action, .oc_mult, .ol_limit, .ol_fail_time, .shed_low, .shed_high, .add_delay, .sub_add_delay,
      .mains_wait, .mains_topo, .gen_topo, .add_req, .sub_req, .unb_warn, .unb_loaddump, .unb_shutdown, .rp_warn,
      .rp_loaddump, .oc_shutdown, .oc_loaddump, .ol_loaddump, .engine_stop, .shed_relay, .load_add_pulse,
      .load_sub_pulse, .gen_release, .mains_vmask, .mains_imask, .mains_delta, .gen_vmask, .gen_imask, .gen_delta);

   // 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Inputs always move 1 ns after the rising edge
   task step(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait, so a dead output cannot hang the run
   task automatic wait_on(ref logic s, input logic v, input int lim);
      int k;
      k = 0;
      while (s !== v && k < lim) begin
         step(1);
         k++;
      end
      chk(s, v);
   endtask
   task reset_check();
      chk({unb_warn, unb_loaddump, unb_shutdown, rp_warn, rp_loaddump, oc_shutdown, oc_loaddump, ol_loaddump,
         engine_stop, shed_relay, load_add_pulse, load_sub_pulse, gen_release, mains_delta, gen_delta}, 16'h0000);
      chk({mains_vmask, mains_imask, gen_vmask, gen_imask}, 16'h0FFF);
   endtask
   task print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Watchdog: the sequence needs under five hundred cycles
   initial begin
      #30000;
      fails++;
      print_verdict();
   end

   // ********************************************************
   // Sequence
   // ********************************************************
   initial begin
      arst_n = 1'b0;
      {rp_warn_limit, rp_ld_limit, oc_limit1, oc_limit2, oc_limit3, ol_limit, shed_low, shed_high, mains_wait} = '0;
      {unb_limit, rp_fail_time, oc_mult, ol_fail_time, sub_add_delay, unb_action, volt_sel, oc_action} = '0;
      {add_delay, add_req, sub_req} = '0;
      mains_topo = 3'h5;
      gen_topo = 3'h5;
      step(6);
      reset_check();
      arst_n = 1'b1;
      step(2);
      // Table cases: unbalance classes and topology decode
      for (int i = 0; i < 13; i++) begin
         unb_limit = rows[i].lim;
         unb_action = rows[i].act;
         mains_topo = rows[i].topo;
         gen_topo = rows[i].topo;
         gs.set_meas(rows[i].hi ? 16'h00A0 : 16'h0064, 18'sh0, 1'b0, 1'b0);
         step(3);
         chk({unb_warn, unb_loaddump, unb_shutdown}, rows[i].unb);
         chk({mains_vmask, mains_imask, mains_delta}, {rows[i].vm, rows[i].im, rows[i].topo == 3'h6});
         chk({gen_vmask, gen_imask, gen_delta}, {rows[i].vm, rows[i].im, rows[i].topo == 3'h6});
      end
      // Reverse power: two seconds to qualify, restart when power recovers
      unb_limit = 7'h00;
      rp_warn_limit = 16'h0032;
      rp_ld_limit = 16'h00C8;
      rp_fail_time = 7'h02;
      gs.set_meas(16'h0064, -18'sh64, 1'b0, 1'b0);
      step(3);
      chk(rp_warn, 1'b0);
      wait_on(rp_warn, 1'b1, 12);
      chk(rp_loaddump, 1'b0);
      gs.set_meas(16'h0064, -18'sh12C, 1'b0, 1'b0);
      wait_on(rp_loaddump, 1'b1, 12);
      gs.set_meas(16'h0064, 18'sh0A, 1'b0, 1'b0);
      wait_on(rp_warn, 1'b0, 3);
      gs.set_meas(16'h0064, -18'sh64, 1'b0, 1'b0);
      step(3);
      chk(rp_warn, 1'b0);
      rp_warn_limit = 16'h0000;
      gs.set_meas(16'h0064, -18'sh12C, 1'b0, 1'b0);
      step(12);
      chk({rp_warn, rp_loaddump}, 2'h0);
      // Overload and overcurrent wait for the contactor; multiplier sets speed
      ol_limit = 16'h0190;
      ol_fail_time = 7'h01;
      oc_limit1 = 16'h0032;
      oc_mult = 7'h10;
      shed_low = 16'h0064;
      shed_high = 16'h012C;
      gs.set_meas(16'h0064, 18'sh1F4, 1'b0, 1'b0);
      step(30);
      chk({ol_loaddump, oc_shutdown, oc_loaddump}, 3'h0);
      chk(shed_relay, 1'b1);
      gs.set_meas(16'h0064, 18'sh1F4, 1'b1, 1'b0);
      wait_on(ol_loaddump, 1'b1, 12);
      step(24);
      chk(oc_shutdown, 1'b0);
      oc_mult = 7'h40;
      wait_on(oc_shutdown, 1'b1, 30);
      step(1);
      chk(engine_stop, 1'b1);
      volt_sel = 2'h1;
      wait_on(oc_shutdown, 1'b0, 6);
      oc_limit2 = 16'h0032;
      oc_action = 2'h1;
      wait_on(oc_loaddump, 1'b1, 30);
      chk(oc_shutdown, 1'b0);
      // Shedding band: hold inside, drop below the low limit
      gs.set_meas(16'h0064, 18'shC8, 1'b1, 1'b0);
      step(3);
      chk(shed_relay, 1'b1);
      gs.set_meas(16'h0064, 18'sh32, 1'b1, 1'b0);
      step(2);
      chk(shed_relay, 1'b0);
      // Load pulses: first add passes, next held two seconds
      add_delay = 8'h02;
      add_req = 1'b1;
      step(1);
      chk(load_add_pulse, 1'b1);
      for (int i = 0; i < 4; i++) begin
         step(1);
         chk(load_add_pulse, 1'b0);
      end
      wait_on(load_add_pulse, 1'b1, 12);
      add_req = 1'b0;
      sub_add_delay = 7'h01;
      sub_req = 1'b1;
      step(1);
      sub_req = 1'b0;
      add_req = 1'b1;
      chk(load_sub_pulse, 1'b1);
      n = 0;
      repeat (200) begin
         step(1);
         n += int'(load_add_pulse);
      end
      chk(n[15:0], 16'h0000);
      wait_on(load_add_pulse, 1'b1, 60);
      add_req = 1'b0;
      // Mains return: release only after the waiting time
      mains_wait = 16'h0003;
      chk(gen_release, 1'b0);
      gs.set_meas(16'h0064, 18'shC8, 1'b1, 1'b1);
      step(3);
      chk(gen_release, 1'b0);
      wait_on(gen_release, 1'b1, 20);
      // Second reset in mid-run returns every output to its reset value at once
      arst_n = 1'b0;
      #1;
      reset_check();
      step(6);
      arst_n = 1'b1;
      step(2);
      print_verdict();
   end
endmodule
`default_nettype wire
